// [hdl/ftpg_lfsr_quad.sv]
`include "ftpg_cfg.svh"

module ftpg_lfsr_quad (
  input wire logic clk,
  input wire logic rst_n,
  ftpg_lfsr_if.gen lf
);

  logic [31:0] state_r;
  logic [31:0] st1;
  logic [31:0] st2;
  logic [31:0] st3;
  logic [31:0] st4;
  logic [31:0] state_nxt;

  // Look-ahead: four successive values per cycle
  assign st1 = ftpg_pkg::lfsr_step(state_r); // [RULE7]
  assign st2 = ftpg_pkg::lfsr_step(st1);
  assign st3 = ftpg_pkg::lfsr_step(st2);
  assign st4 = ftpg_pkg::lfsr_step(st3);
  assign lf.words = {st3, st2, st1, state_r};
  assign state_nxt = lf.load ? lf.seed : (lf.advance ? st4 : state_r);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= `FTPG_LFSR_RST;
    else
      state_r <= state_nxt;
  end

endmodule // ftpg_lfsr_quad

// [hdl/ftpg_top.sv]
// The address map and the address-and-strobe port are this design's own decisions.
`include "ftpg_cfg.svh"

// Function
// [RULE1] Each 512-byte block opens with address word then zero word, then data; code omits this header in all-zero and all-one patterns.
// [RULE2] Header comes from a block address counter in 512-byte units.
// [RULE3] Start loads address counter with first file index times file size.
// [RULE4] Address counter steps by one after each complete 512-byte block.
// [RULE5] Selector picks pattern; incremental from data counter, decremental inverted.
// [RULE6] Random words use a 32-bit LFSR, polynomial x^31+x^21+x+1.
// [RULE7] Two 128-bit halves, distinct seeds, four LFSR steps per cycle each; code's two seeds match where address bits 31:16 equal inverted 15:0.
// [RULE8] Seed mixes block address bits with inverted block address bits.
// [RULE9] A mismatching read word sets the pattern fail flag.
// [RULE10] One-cycle start pulse sets write active, enabling FIFO writes.
// [RULE11] Write enable high while write active and almost-full low.
// [RULE12] Almost-full high holds write enable low.
// [RULE13] Each write-enable cycle increments the transfer counter.
// [RULE14] Count reaching end size clears write active and write enable.
// [RULE15] Read enable follows only the empty flag, no start, no count stop; code also skips the cycle after each read.
// [RULE16] Each read-enable cycle advances data and address counters.
// [RULE17] Both directions use 256-bit FIFO-style data ports.
// [RULE18] End size is file count times decoded file size.
// [RULE19] Selector also offers all-zero and all-one, five patterns total.
// [RULE20] Read whenever empty is low and compare each word with expected; code skips the cycle after each read.
// [RULE21] Start clears data counter and fail flag; fail sticks until then.
// [RULE22] Data counter steps once per 32-bit word position, header overlaid.
module ftpg_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  output logic fifoWriteEnable,
  output logic [255:0] fifoWriteWord,
  input wire logic fifoAlmostFull,
  output logic fifoReadEnable,
  input wire logic [255:0] fifoReadWord,
  input wire logic fifoEmptyFlag,
  output logic writeTransferActive,
  output logic patternFailFlag
);

  // Software registers
  logic [2:0] pattSel_r;
  logic [15:0] firstFileIndex_r;
  logic [15:0] fileCount_r;
  logic [2:0] fileSizeCode_r;
  logic [31:0] regRdData_r;

  // Transfer control
  ftpg_pkg::ftpg_wstate_type wstate_r;
  ftpg_pkg::ftpg_wstate_type wstate_nxt;
  logic active_r;
  logic wrEn_r;
  logic wrEn_nxt;
  ftpg_pkg::ftpg_word_type wrWord_r;
  logic [39:0] xferCnt_r;
  logic [39:0] xferCnt_nxt;

  // Pattern generator state
  ftpg_pkg::ftpg_addr_type blockAddr_r;
  ftpg_pkg::ftpg_addr_type blockAddr_nxt;
  logic [3:0] wordIdx_r;
  logic [3:0] wordIdx_nxt;
  ftpg_pkg::ftpg_dw_type dataCnt_r;
  ftpg_pkg::ftpg_dw_type dataCnt_nxt;

  // Read checker
  logic rdEn_r;
  logic rdEn_nxt;
  logic rdVal_r;
  ftpg_pkg::ftpg_word_type expWord_r;
  logic fail_r;
  logic fail_nxt;

  // Decode
  wire selCmd = regAddr == `FTPG_ADDR_CMD;
  wire selPatt = regAddr == `FTPG_ADDR_PATT;
  wire selFirst = regAddr == `FTPG_ADDR_FIRST;
  wire selCount = regAddr == `FTPG_ADDR_COUNT;
  wire selFsize = regAddr == `FTPG_ADDR_FILE_SIZE_CODE;
  wire selStatus = regAddr == `FTPG_ADDR_STATUS;
  wire selXfer = regAddr == `FTPG_ADDR_XFER;
  wire writePatternStart = regWrEn && selCmd && regWrData[`FTPG_CMD_WSTART];
  wire readPatternStart = regWrEn && selCmd && regWrData[`FTPG_CMD_RSTART];
  wire anyStart = writePatternStart || readPatternStart;

  wire [18:0] fileSectors = ftpg_pkg::file_sectors(fileSizeCode_r);
  // Operands widened first so a large file index cannot wrap the product
  wire [34:0] startProd = 35'(firstFileIndex_r) * 35'(fileSectors);
  wire [34:0] endProd = 35'(fileCount_r) * 35'(fileSectors);
  // Start address in 512-byte blocks
  wire [47:0] startAddr = {13'h0000, startProd}; // [RULE3]
  // End size counted in 256-bit words, sixteen per block
  wire [39:0] endSize = {1'b0, endProd, 4'h0}; // [RULE18]
  wire endNonZero = endSize != 40'h00_0000_0000;
  wire lastWord = (xferCnt_r + 40'h00_0000_0001) == endSize;

  // Write sequencing
  always_comb
  begin
    wstate_nxt = wstate_r;
    case (wstate_r)
      ftpg_pkg::WR_IDLE:
      begin
        if (writePatternStart && endNonZero)
          wstate_nxt = ftpg_pkg::WR_RUN; // [RULE10]
      end
      ftpg_pkg::WR_RUN:
      begin
        if (wrEn_r && lastWord)
          wstate_nxt = ftpg_pkg::WR_IDLE; // [RULE14]
      end
      default:
        wstate_nxt = ftpg_pkg::WR_IDLE;
    endcase
  end

  // Enable drops on the edge that takes the last word, never one word late
  assign wrEn_nxt = (wstate_r == ftpg_pkg::WR_RUN) // [RULE11]
    && !fifoAlmostFull // [RULE12]
    && !(wrEn_r && lastWord); // [RULE14]

  assign xferCnt_nxt = anyStart ? 40'h00_0000_0000 :
    ((wrEn_r || rdEn_r) ? xferCnt_r + 40'h00_0000_0001 : xferCnt_r); // [RULE13]

  // Read enable is registered, so after each read one cycle is skipped to
  // let the empty flag catch up; this avoids reading an empty FIFO
  assign rdEn_nxt = !fifoEmptyFlag && !rdEn_r; // [RULE15] [RULE20]

  // Generator advances on every word it delivers or expects
  wire genAdv = wrEn_nxt || rdEn_r; // [RULE16]
  wire blockEnd = wordIdx_r == `FTPG_LAST_IDX;
  wire [47:0] nextAddr = blockAddr_r + 48'h0000_0000_0001;

  always_comb
  begin
    blockAddr_nxt = blockAddr_r;
    wordIdx_nxt = wordIdx_r;
    dataCnt_nxt = dataCnt_r;
    if (anyStart)
    begin
      blockAddr_nxt = startAddr; // [RULE3]
      wordIdx_nxt = 4'h0;
      dataCnt_nxt = 32'h0000_0000; // [RULE21]
    end
    else if (genAdv)
    begin
      wordIdx_nxt = wordIdx_r + 4'h1;
      dataCnt_nxt = dataCnt_r + `FTPG_DW_PER_WORD; // [RULE22]
      if (blockEnd)
        blockAddr_nxt = nextAddr; // [RULE2] [RULE4]
    end
  end

  // LFSR halves: reseeded at transfer start and at each block boundary
  ftpg_lfsr_if lfLow ();
  ftpg_lfsr_if lfHigh ();
  wire lfLoad = anyStart || (genAdv && blockEnd);
  wire [31:0] seedAddr = anyStart ? startAddr[31:0] : nextAddr[31:0];

  assign lfLow.load = lfLoad;
  assign lfLow.advance = genAdv;
  assign lfLow.seed = ftpg_pkg::lfsr_seed(seedAddr, 1'b0); // [RULE8]
  assign lfHigh.load = lfLoad;
  assign lfHigh.advance = genAdv;
  assign lfHigh.seed = ftpg_pkg::lfsr_seed(seedAddr, 1'b1); // [RULE8]

  ftpg_lfsr_quad uLfsrLow (
    .clk(clk),
    .rst_n(rst_n),
    .lf(lfLow)
  ); // [RULE6] [RULE7]

  ftpg_lfsr_quad uLfsrHigh (
    .clk(clk),
    .rst_n(rst_n),
    .lf(lfHigh)
  ); // [RULE6] [RULE7]

  wire [255:0] rndWord = {lfHigh.words, lfLow.words};
  wire hdrWord = wordIdx_r == 4'h0;
  ftpg_pkg::ftpg_word_type genWord;

  genvar lane;
  generate
    for (lane = 0; lane < 8; lane++)
    begin : gLane
      // Header overlays lanes 0 and 1 of the first word of each block, except in the all-zero and all-one patterns
      assign genWord[32 * lane +: 32] = ftpg_pkg::lane_word(pattSel_r,
        3'(lane), hdrWord, blockAddr_r[31:0], dataCnt_r + 32'(lane),
        rndWord[32 * lane +: 32]); // [RULE1] [RULE5] [RULE19]
    end
  endgenerate

  // Compare one cycle after the read enable, when the FIFO shows the word
  wire mismatch = rdVal_r && (fifoReadWord != expWord_r); // [RULE20]
  assign fail_nxt = mismatch || (fail_r && !anyStart); // [RULE9] [RULE21]

  // Read mux
  // Start pulses are not stored, so the command register reads back as zero
  logic [31:0] rdMux;
  always_comb
  begin
    rdMux = 32'h0000_0000;
    if (selPatt)
      rdMux = {29'h0000_0000, pattSel_r};
    else if (selFirst)
      rdMux = {16'h0000, firstFileIndex_r};
    else if (selCount)
      rdMux = {16'h0000, fileCount_r};
    else if (selFsize)
      rdMux = {29'h0000_0000, fileSizeCode_r};
    else if (selStatus)
    begin
      rdMux[`FTPG_STAT_ACTIVE] = active_r;
      rdMux[`FTPG_STAT_FAIL] = fail_r;
    end
    else if (selXfer)
      rdMux = xferCnt_r[31:0];
  end

  // Software registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pattSel_r <= `FTPG_PATT_RST;
      firstFileIndex_r <= `FTPG_FIRST_RST;
      fileCount_r <= `FTPG_COUNT_RST;
      fileSizeCode_r <= `FTPG_FILE_SIZE_CODE_RST;
    end
    else if (regWrEn)
    begin
      if (selPatt)
        pattSel_r <= regWrData[2:0];
      if (selFirst)
        firstFileIndex_r <= regWrData[15:0];
      if (selCount)
        fileCount_r <= regWrData[15:0];
      if (selFsize)
        fileSizeCode_r <= regWrData[2:0];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdData_r <= 32'h0000_0000;
    else
      regRdData_r <= regRdEn ? rdMux : 32'h0000_0000;
  end

  // Write path
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wstate_r <= ftpg_pkg::WR_IDLE;
      active_r <= 1'b0;
      wrEn_r <= 1'b0;
    end
    else
    begin
      wstate_r <= wstate_nxt;
      active_r <= wstate_nxt == ftpg_pkg::WR_RUN; // [RULE10] [RULE14]
      wrEn_r <= wrEn_nxt;
    end
  end

  // Word counter, shared by both directions and readable by software
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      xferCnt_r <= 40'h00_0000_0000;
    else
      xferCnt_r <= xferCnt_nxt; // [RULE13]
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wrWord_r <= 256'h0;
    else if (wrEn_nxt)
      wrWord_r <= genWord; // [RULE17]
  end

  // Generator counters
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wordIdx_r <= 4'h0;
      dataCnt_r <= 32'h0000_0000;
    end
    else
    begin
      wordIdx_r <= wordIdx_nxt;
      dataCnt_r <= dataCnt_nxt;
    end
  end

  // Block address counter in 512-byte units
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      blockAddr_r <= 48'h0000_0000_0000;
    else
      blockAddr_r <= blockAddr_nxt; // [RULE2] [RULE4]
  end

  // Read checker
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdEn_r <= 1'b0;
      rdVal_r <= 1'b0;
    end
    else
    begin
      rdEn_r <= rdEn_nxt;
      rdVal_r <= rdEn_r;
    end
  end

  // Sticky until the next start; a mismatch in the start cycle still wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fail_r <= 1'b0;
    else
      fail_r <= fail_nxt; // [RULE9] [RULE21]
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      expWord_r <= 256'h0;
    else if (rdEn_r)
      expWord_r <= genWord; // [RULE16]
  end

  assign regRdData = regRdData_r;
  assign fifoWriteEnable = wrEn_r;
  assign fifoWriteWord = wrWord_r;
  assign fifoReadEnable = rdEn_r;
  assign writeTransferActive = active_r;
  assign patternFailFlag = fail_r;

endmodule // ftpg_top

// [pkg/ftpg_cfg.svh]
`ifndef FTPG_CFG_SVH
`define FTPG_CFG_SVH

// Register byte offsets
`define FTPG_ADDR_CMD 8'h00
`define FTPG_ADDR_PATT 8'h04
`define FTPG_ADDR_FIRST 8'h08
`define FTPG_ADDR_COUNT 8'h0C
`define FTPG_ADDR_FILE_SIZE_CODE 8'h10
`define FTPG_ADDR_STATUS 8'h14
`define FTPG_ADDR_XFER 8'h18

// Field positions
`define FTPG_CMD_WSTART 0
`define FTPG_CMD_RSTART 1
`define FTPG_STAT_ACTIVE 0
`define FTPG_STAT_FAIL 1

// Pattern selector codes
`define FTPG_PATT_ZERO 3'h0
`define FTPG_PATT_ONE 3'h1
`define FTPG_PATT_INC 3'h2
`define FTPG_PATT_DEC 3'h3
`define FTPG_PATT_LFSR 3'h4

// Reset values
`define FTPG_PATT_RST 3'h2
`define FTPG_FIRST_RST 16'h0000
`define FTPG_COUNT_RST 16'h0001
`define FTPG_FILE_SIZE_CODE_RST 3'h0
`define FTPG_LFSR_RST 32'h0000_0001

// Sizes and counts
`define FTPG_SECT_BASE 19'h00800
`define FTPG_DW_PER_WORD 32'h0000_0008
`define FTPG_LAST_IDX 4'hF
`define FTPG_HDR_HI 32'h0000_0000

`endif

// [pkg/ftpg_lfsr_if.sv]
interface ftpg_lfsr_if;
  logic load;
  logic advance;
  logic [31:0] seed;
  logic [127:0] words;
  modport ctrl (output load, output advance, output seed, input words);
  modport gen (input load, input advance, input seed, output words);
endinterface

// [pkg/ftpg_pkg.sv]
`include "ftpg_cfg.svh"

package ftpg_pkg;

  typedef logic [31:0] ftpg_dw_type;
  typedef logic [255:0] ftpg_word_type;
  typedef logic [47:0] ftpg_addr_type;
  typedef enum logic {WR_IDLE, WR_RUN} ftpg_wstate_type;

  // File size in 512-byte blocks: 1 MiB doubled per code step
  function automatic logic [18:0] file_sectors(input logic [2:0] code);
    file_sectors = `FTPG_SECT_BASE << code;
  endfunction

  function automatic ftpg_dw_type lfsr_step(input ftpg_dw_type s);
    lfsr_step = {s[30:0], s[30] ^ s[20] ^ s[0]};
  endfunction

  // Address mixed with its inverse, so the seed is never all zero
  function automatic ftpg_dw_type lfsr_seed(input ftpg_dw_type a, input logic half);
    lfsr_seed = half ? {~a[31:16], a[31:16]} : {a[15:0], ~a[15:0]};
  endfunction

  function automatic ftpg_dw_type lane_word(input logic [2:0] sel, input logic [2:0] lane,
      input logic hdr, input ftpg_dw_type addrLo, input ftpg_dw_type inc,
      input ftpg_dw_type rnd);
    lane_word = 32'h0000_0000;
    case (sel)
      `FTPG_PATT_ZERO: lane_word = 32'h0000_0000;
      `FTPG_PATT_ONE: lane_word = 32'hFFFF_FFFF;
      default:
      begin
        if (hdr && lane == 3'h0)
          lane_word = addrLo;
        else if (hdr && lane == 3'h1)
          lane_word = `FTPG_HDR_HI;
        else if (sel == `FTPG_PATT_INC)
          lane_word = inc;
        else if (sel == `FTPG_PATT_DEC)
          lane_word = ~inc;
        else if (sel == `FTPG_PATT_LFSR)
          lane_word = rnd;
      end
    endcase
  endfunction

endpackage

// [sim/ftpg_fifo_model.sv]
module ftpg_fifo_model #(parameter int KEEP = 32) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic writeEnable,
  input wire logic [255:0] writeWord,
  input wire logic readEnable,
  input wire logic stall,
  input wire logic replay,
  input wire logic corrupt,
  output logic almostFull,
  output logic emptyFlag,
  output logic [255:0] readWord
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [255:0] kept[$];
  int nKept;
  int rdPtr;
  assign almostFull = stall;
  assign emptyFlag = !(replay && rdPtr < nKept);
  // Only the head of the stream is kept and replayed, to bound memory and run time
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      kept.delete();
      nKept <= 0;
      rdPtr <= 0;
      readWord <= 256'h0;
    end
    else
    begin
      if (writeEnable && nKept < KEEP)
      begin
        kept.push_back(writeWord);
        nKept <= nKept + 1;
      end
      if (!replay)
        rdPtr <= 0;
      else if (readEnable && rdPtr < nKept)
      begin
        readWord <= kept[rdPtr] ^ {255'h0, corrupt && rdPtr == 5};
        rdPtr <= rdPtr + 1;
      end
      else
        readWord <= ~readWord; // Stale data must never look valid
    end
  end
endmodule // ftpg_fifo_model

// [sim/ftpg_top_sva.sv]
module ftpg_top_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [31:0] regRdData,
  input wire logic fifoWriteEnable,
  input wire logic [255:0] fifoWriteWord,
  input wire logic fifoAlmostFull,
  input wire logic fifoReadEnable,
  input wire logic [255:0] fifoReadWord,
  input wire logic fifoEmptyFlag,
  input wire logic writeTransferActive,
  input wire logic patternFailFlag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire startWr = regWrEn && regAddr == 8'h00 && regWrData[0];
  wire startAny = regWrEn && regAddr == 8'h00 && regWrData[1:0] != 2'h0;

  a_wr_gate: assert property (fifoWriteEnable |->
    $past(writeTransferActive) && !$past(fifoAlmostFull)) else $error("write without cause");
  a_af_pause: assert property (fifoAlmostFull |=> !fifoWriteEnable)
    else $error("write while almost full");
  a_wr_runs: assert property (writeTransferActive && !fifoAlmostFull |=>
    fifoWriteEnable || !writeTransferActive) else $error("write stalled");
  a_start_active: assert property (startWr |=> writeTransferActive)
    else $error("start ignored");
  a_end_both: assert property ($fell(writeTransferActive) |->
    !fifoWriteEnable && $past(fifoWriteEnable)) else $error("bad end of write");
  a_rd_empty: assert property (fifoReadEnable |-> !$past(fifoEmptyFlag))
    else $error("read from empty");
  a_rd_issue: assert property (!fifoEmptyFlag && !fifoReadEnable |=> fifoReadEnable)
    else $error("read not issued");
  a_fail_sticky: assert property (patternFailFlag && !startAny |=> patternFailFlag)
    else $error("fail flag dropped");
  a_fail_cause: assert property ($rose(patternFailFlag) |-> $past(fifoReadEnable, 2))
    else $error("fail without read");

  cover property (fifoWriteEnable ##1 fifoAlmostFull);
  cover property ($fell(writeTransferActive));
  cover property ($rose(patternFailFlag));
endmodule // ftpg_top_sva

bind ftpg_top ftpg_top_sva i_sva (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .fifoWriteEnable(fifoWriteEnable), .fifoWriteWord(fifoWriteWord),
  .fifoAlmostFull(fifoAlmostFull), .fifoReadEnable(fifoReadEnable),
  .fifoReadWord(fifoReadWord), .fifoEmptyFlag(fifoEmptyFlag),
  .writeTransferActive(writeTransferActive), .patternFailFlag(patternFailFlag));

// [sim/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n, regWrEn, regRdEn, stall, replay, corrupt, af, empty, wrEn, rdEn, active, fail;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData, d;
  logic [255:0] wrWord, rdWord;
  int n_mismatch = 0;
  int n_compared = 0;
  int nWr = 0;
  int i;
  int pats[4] = '{0, 1, 3, 4};

  ftpg_top i_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .fifoWriteEnable(wrEn),
    .fifoWriteWord(wrWord), .fifoAlmostFull(af), .fifoReadEnable(rdEn),
    .fifoReadWord(rdWord), .fifoEmptyFlag(empty), .writeTransferActive(active),
    .patternFailFlag(fail));
  ftpg_fifo_model i_fifo (.clk(clk), .rst_n(rst_n), .writeEnable(wrEn), .writeWord(wrWord),
    .readEnable(rdEn), .stall(stall), .replay(replay), .corrupt(corrupt),
    .almostFull(af), .emptyFlag(empty), .readWord(rdWord));

  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    if (!rst_n)
      nWr <= 0;
    else if (wrEn)
      nWr <= nWr + 1;
  end

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask

  task chk(input string name, input logic [255:0] exp, input logic [255:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task wait_kept(input int n);
    for (i = 0; i < 300 && i_fifo.nKept < n; i++) @(posedge clk);
  endtask

  task wait_read;
    for (i = 0; i < 300 && i_fifo.rdPtr < 32; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
  endtask

  function automatic logic [31:0] st(input logic [31:0] s);
    return {s[30:0], s[30] ^ s[20] ^ s[0]};
  endfunction

  // Expected word w of a stream starting at block 3 * 2048
  function automatic logic [255:0] ew(input int p, input int w);
    logic [255:0] r;
    logic [31:0] a, s0, s1;
    a = 32'h0000_1800 + w / 16;
    s0 = {a[15:0], ~a[15:0]};
    s1 = {~a[31:16], a[31:16]};
    repeat (4 * (w % 16))
    begin
      s0 = st(s0);
      s1 = st(s1);
    end
    for (int k = 0; k < 4; k++)
    begin
      r[32 * k +: 32] = s0;
      r[128 + 32 * k +: 32] = s1;
      s0 = st(s0);
      s1 = st(s1);
    end
    for (int k = 0; k < 8; k++)
      if (p == 2 || p == 3)
        r[32 * k +: 32] = (p == 3) ? ~32'(w * 8 + k) : 32'(w * 8 + k);
    if (p == 0)
      r = 256'h0;
    if (p == 1)
      r = ~256'h0;
    if (p > 1 && w % 16 == 0)
      r[63:0] = {32'h0000_0000, a};
    return r;
  endfunction

  initial
  begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("unexpected timeout: expected end seen hang");
    finish_test;
  end

  initial
  begin
    {rst_n, regWrEn, regRdEn, stall, replay, corrupt, regAddr, regWrData} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h04);
    chk("pattern", 2, d);
    rd(8'h0C);
    chk("count", 1, d);
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14);
    chk("status", 0, d);
    rd(8'h40);
    chk("unmapped", 0, d);
    rd(8'h00);
    chk("command", 0, d);
    foreach (pats[j])
    begin
      wr(8'h04, pats[j]);
      wr(8'h08, 3);
      wr(8'h00, 1);
      wait_kept(4);
      stall <= 1'b1;
      repeat (6) @(posedge clk);
      stall <= 1'b0;
      wait_kept(32);
      for (int w = 0; w < 32; w++)
        chk("word", ew(pats[j], w), i_fifo.kept[w]);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
    end
    wr(8'h08, 3);
    wr(8'h00, 1);
    repeat (2) @(posedge clk);
    for (i = 0; i < 40000 && active === 1'b1; i++)
      @(posedge clk);
    #1;
    chk("writes", 32768, nWr);
    chk("wrEn", 0, wrEn);
    for (int w = 0; w < 32; w++)
      chk("word", ew(2, w), i_fifo.kept[w]);
    rd(8'h18);
    chk("xfer", 32768, d);
    wr(8'h00, 2);
    replay <= 1'b1;
    wait_read;
    chk("fail", 0, fail);
    replay <= 1'b0;
    wr(8'h00, 2);
    corrupt <= 1'b1;
    replay <= 1'b1;
    wait_read;
    chk("fail", 1, fail);
    repeat (20) @(posedge clk);
    rd(8'h14);
    chk("status", 2, d);
    wr(8'h00, 2);
    rd(8'h14);
    chk("status", 0, d);
    wr(8'h10, 32'h0000_0007);
    rd(8'h10);
    chk("file_size_code", 7, d);
    finish_test;
  end
endmodule // tb_top
